// file: logic/tsf_pkg.sv
// Package with bit positions, reset values and encodings for the terminal status flags.
package tsf_pkg;
    localparam int          BIT_RAM_INIT_FAIL   = 0;
    localparam int          BIT_CHECKSUM_ERROR  = 1;
    localparam int          BIT_TERM_A_INHIBIT  = 2;
    localparam int          BIT_TERM_B_INHIBIT  = 3;
    localparam int          BIT_TERM_A_MSG      = 4;
    localparam int          BIT_TERM_B_MSG      = 5;
    localparam int          BIT_MON_PACKET      = 6;
    localparam int          BIT_MON_MSG         = 7;
    localparam int          BIT_CTRL_RUNNING    = 8;
    localparam int          BIT_MONITOR_RESET   = 12;
    localparam int          BIT_TERM_B_RESET    = 11;
    localparam int          BIT_TERM_A_RESET    = 10;
    localparam int          BIT_AUTOINIT        = 13;
    localparam int          PEND_CHECKSUM_BIT   = 14;
    localparam int          PEND_RAM_FAIL_BIT   = 13;
    localparam logic [15:0] HW_PENDING_OFFSET   = 16'h0006;
    localparam logic [8:0]  STATUS_RESET        = 9'h000;
    localparam logic [2:0]  SOFT_RESET_RESET    = 3'h0;
    localparam logic [1:0]  BUS_NONE            = 2'h0;
    localparam logic [1:0]  BUS_A_SHUT          = 2'h1;
    localparam logic [1:0]  BUS_B_SHUT          = 2'h2;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       strap;
        logic [8:0] status;
        logic [2:0] soft_reset;
        logic [1:0] bit_word_a;
        logic [1:0] bit_word_b;
        logic       pend_checksum;
        logic       pend_ram_fail;
    } tsf_state_s;
endpackage

// file: logic/tsf_status.sv
// Low status field of the master status and soft reset register.
`timescale 1ns/1ps

// Overview of operation
// - Bit 8 follows controller enabled and running.
// - Bit 7 sets on command, clears at end.
// - Bit 6 tracks monitor packet start to completion.
// - Bit 5 tracks second terminal message.
// - Bit 4 tracks first terminal message.
// - Bit 3 high while second terminal bus shut.
// - Second inhibit ends: override, reset, soft reset.
// - Bit 2 high while first terminal bus shut.
// - First inhibit ends: override, reset, soft reset.
// - Shut bus recorded in terminal test word.
// - Checksum failure sets bit 1, pending 14.
// - Checksum flag only with auto-init strapped.
// - RAM mismatch sets bit 0, pending 13.
// - RAM check only with auto-init strapped.
// - Strap captured at master reset release.
// - Soft reset bits self-clear when done.
module tsf_status
    import tsf_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        AUTOINIT_PIN,
    input  wire logic        CTRL_ENABLED,
    input  wire logic        CTRL_EXECUTING,
    input  wire logic        MON_CMD_VALID,
    input  wire logic        MON_MSG_DONE,
    input  wire logic        MON_PACKET_START,
    input  wire logic        MON_PACKET_DONE,
    input  wire logic        TERM_A_CMD_VALID,
    input  wire logic        TERM_A_MSG_DONE,
    input  wire logic        TERM_B_CMD_VALID,
    input  wire logic        TERM_B_MSG_DONE,
    input  wire logic        TERM_A_SHUTDOWN,
    input  wire logic        TERM_A_OVERRIDE,
    input  wire logic        TERM_B_SHUTDOWN,
    input  wire logic        TERM_B_OVERRIDE,
    input  wire logic        SHUT_BUS_B,
    input  wire logic        CHECKSUM_FAIL,
    input  wire logic        RAM_MISMATCH,
    input  wire logic        SOFT_RESET_DONE_A,
    input  wire logic        SOFT_RESET_DONE_B,
    input  wire logic        SOFT_RESET_DONE_MON,
    input  wire logic        HOST_WRITE,
    input  wire logic [15:0] HOST_WDATA,
    input  wire logic        PEND_READ,
    output logic      [15:0] STATUS_WORD,
    output logic      [1:0]  TERM_A_BIT_WORD,
    output logic      [1:0]  TERM_B_BIT_WORD,
    output logic      [15:0] HW_PENDING,
    output logic             SOFT_RESET_ACTIVE
);
    tsf_state_s r;
    tsf_state_s next_r;

    function automatic logic [1:0] shut_code(input logic bus_b);
        shut_code = bus_b ? BUS_B_SHUT : BUS_A_SHUT;
    endfunction

    always_comb begin
        logic [2:0] wr_req;
        logic [2:0] done;
        logic       clr_a;
        logic       clr_b;
        logic       en;
        wr_req = {HOST_WDATA[BIT_MONITOR_RESET], HOST_WDATA[BIT_TERM_B_RESET],
                  HOST_WDATA[BIT_TERM_A_RESET]};
        done   = {SOFT_RESET_DONE_MON, SOFT_RESET_DONE_B, SOFT_RESET_DONE_A};
        next_r = r;
        next_r.sync1 = AUTOINIT_PIN;
        next_r.sync2 = r.sync1;
        en = r.strap;
        // Soft reset bits: host writes start a reset only when idle.
        next_r.soft_reset = (r.soft_reset & ~done)
                          | (HOST_WRITE && r.soft_reset == SOFT_RESET_RESET ? wr_req : 3'h0);
        clr_a = TERM_A_OVERRIDE || next_r.soft_reset[0];
        clr_b = TERM_B_OVERRIDE || next_r.soft_reset[1];
        next_r.status[BIT_CTRL_RUNNING] = CTRL_ENABLED && CTRL_EXECUTING;
        if (MON_CMD_VALID) begin
            next_r.status[BIT_MON_MSG] = 1'b1;
        end else if (MON_MSG_DONE) begin
            next_r.status[BIT_MON_MSG] = 1'b0;
        end
        if (MON_PACKET_START) begin
            next_r.status[BIT_MON_PACKET] = 1'b1;
        end else if (MON_PACKET_DONE) begin
            next_r.status[BIT_MON_PACKET] = 1'b0;
        end
        if (TERM_B_CMD_VALID) begin
            next_r.status[BIT_TERM_B_MSG] = 1'b1;
        end else if (TERM_B_MSG_DONE) begin
            next_r.status[BIT_TERM_B_MSG] = 1'b0;
        end
        if (TERM_A_CMD_VALID) begin
            next_r.status[BIT_TERM_A_MSG] = 1'b1;
        end else if (TERM_A_MSG_DONE) begin
            next_r.status[BIT_TERM_A_MSG] = 1'b0;
        end
        if (TERM_B_SHUTDOWN) begin
            next_r.status[BIT_TERM_B_INHIBIT] = 1'b1;
            next_r.bit_word_b = shut_code(SHUT_BUS_B);
        end else if (clr_b) begin
            next_r.status[BIT_TERM_B_INHIBIT] = 1'b0;
            next_r.bit_word_b = BUS_NONE;
        end
        if (TERM_A_SHUTDOWN) begin
            next_r.status[BIT_TERM_A_INHIBIT] = 1'b1;
            next_r.bit_word_a = shut_code(SHUT_BUS_B);
        end else if (clr_a) begin
            next_r.status[BIT_TERM_A_INHIBIT] = 1'b0;
            next_r.bit_word_a = BUS_NONE;
        end
        // Pending bits clear on read, but a new failure in the same cycle wins.
        if (PEND_READ) begin
            next_r.pend_checksum = 1'b0;
            next_r.pend_ram_fail = 1'b0;
        end
        if (CHECKSUM_FAIL && en) begin
            next_r.status[BIT_CHECKSUM_ERROR] = 1'b1;
            next_r.pend_checksum = 1'b1;
        end
        if (RAM_MISMATCH && en) begin
            next_r.status[BIT_RAM_INIT_FAIL] = 1'b1;
            next_r.pend_ram_fail = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r            <= '0;
            // The pin keeps moving through the synchroniser while reset is held.
            r.sync1      <= AUTOINIT_PIN;
            r.sync2      <= r.sync1;
            // The strap keeps the synchronised level seen at the last reset edge.
            r.strap      <= r.sync2;
            r.status     <= STATUS_RESET;
            r.soft_reset <= SOFT_RESET_RESET;
            r.bit_word_a <= BUS_NONE;
            r.bit_word_b <= BUS_NONE;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            STATUS_WORD       <= 16'h0000;
            TERM_A_BIT_WORD   <= BUS_NONE;
            TERM_B_BIT_WORD   <= BUS_NONE;
            HW_PENDING        <= 16'h0000;
            SOFT_RESET_ACTIVE <= 1'b0;
        end else begin
            STATUS_WORD <= {2'h0, r.strap, next_r.soft_reset[2], next_r.soft_reset[1],
                            next_r.soft_reset[0], 1'b0, next_r.status};
            TERM_A_BIT_WORD   <= next_r.bit_word_a;
            TERM_B_BIT_WORD   <= next_r.bit_word_b;
            HW_PENDING        <= {1'b0, next_r.pend_checksum, next_r.pend_ram_fail, 13'h0000};
            SOFT_RESET_ACTIVE <= |next_r.soft_reset;
        end
    end

endmodule // tsf_status

// file: test/tsf_props.sv
// Checker for the terminal status flag outputs.
`timescale 1ns/1ps
module tsf_props
    import tsf_pkg::*;
(
    input wire logic        CLK, RST, CTRL_ENABLED, CTRL_EXECUTING, MON_CMD_VALID,
    input wire logic        MON_PACKET_START, MON_PACKET_DONE, TERM_A_CMD_VALID,
    input wire logic        TERM_A_MSG_DONE, TERM_A_SHUTDOWN, TERM_B_SHUTDOWN,
    input wire logic        TERM_B_OVERRIDE, SHUT_BUS_B, CHECKSUM_FAIL, RAM_MISMATCH,
    input wire logic        HOST_WRITE, SOFT_RESET_ACTIVE,
    input wire logic [15:0] HOST_WDATA, STATUS_WORD, HW_PENDING,
    input wire logic [1:0]  TERM_A_BIT_WORD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_take_a;
        HOST_WRITE && HOST_WDATA[10] && !SOFT_RESET_ACTIVE && !TERM_A_SHUTDOWN;
    endsequence
    sequence s_hold_a;
        STATUS_WORD[10] && SOFT_RESET_ACTIVE && !STATUS_WORD[2];
    endsequence
    chk_run_flag: assert property (
        1'b1 |=> STATUS_WORD[8] == $past(CTRL_ENABLED && CTRL_EXECUTING)) else $error("run");
    chk_mon_msg: assert property (
        MON_CMD_VALID |=> STATUS_WORD[7]) else $error("mon msg");
    chk_pkt_end: assert property (
        MON_PACKET_DONE && !MON_PACKET_START |=> !STATUS_WORD[6]) else $error("packet");
    chk_a_msg_end: assert property (
        TERM_A_MSG_DONE && !TERM_A_CMD_VALID |=> !STATUS_WORD[4]) else $error("a msg");
    chk_a_inhibit: assert property (
        TERM_A_SHUTDOWN |=> STATUS_WORD[2]
        && TERM_A_BIT_WORD == ($past(SHUT_BUS_B) ? BUS_B_SHUT : BUS_A_SHUT)) else $error("inh");
    chk_b_override: assert property (
        TERM_B_OVERRIDE && !TERM_B_SHUTDOWN |=> !STATUS_WORD[3]) else $error("override");
    chk_sum_set: assert property (
        CHECKSUM_FAIL && STATUS_WORD[13] |=> STATUS_WORD[1] && HW_PENDING[14]) else $error("sum");
    chk_ram_gate: assert property (
        !$past(RST) && RAM_MISMATCH && !STATUS_WORD[13] && !STATUS_WORD[0] |=> !STATUS_WORD[0])
        else $error("ram");
    chk_soft_a: assert property (
        s_take_a |=> s_hold_a) else $error("soft a");
endmodule // tsf_props
bind tsf_status tsf_props u_tsf_props (.*);

// file: test/tsf_host.sv
// Host model issuing random status writes and pending register reads.
`timescale 1ns/1ps
module tsf_host (
    input  wire logic   CLK, EN,
    output logic        HOST_WRITE = 0, PEND_READ = 0,
    output logic [15:0] HOST_WDATA = 0
);
    int seed = 16242;
    always @(posedge CLK) begin
        HOST_WRITE <= EN && $random(seed) % 11 == 0;
        HOST_WDATA <= 16'($random(seed));
        PEND_READ  <= EN && $random(seed) % 7 == 0;
    end
endmodule // tsf_host

// file: test/tb_tsf_status.sv
// Random self-checking bench for the terminal status flags.
`timescale 1ns/1ps
`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin errors++; \
    $display("wrong value at %0t: %h vs %h", $time, g, w); end end
module tb_tsf_status
    import tsf_pkg::*;
;
    typedef struct packed {logic [15:0] sw; logic [1:0] a, b, hp;} tsf_exp_s;
    logic        clk = 0, rst = 1, pin = 0, en = 0, hw, pr, sr_act;
    logic [19:0] ev = '0;
    logic [15:0] hwd, sw_out, hp_out;
    logic [1:0]  a_word, b_word;
    tsf_exp_s    want;
    int          seed = 16242, errors = 0, comparisons = 0, live = 0;
    always #2 clk = ~clk;
    tsf_host u_tsf_host (.CLK(clk), .EN(en), .HOST_WRITE(hw), .HOST_WDATA(hwd), .PEND_READ(pr));
    tsf_status u_tsf_status (.CLK(clk), .RST(rst), .AUTOINIT_PIN(pin), .CTRL_ENABLED(ev[0]),
        .CTRL_EXECUTING(ev[1]), .MON_CMD_VALID(ev[2]), .MON_MSG_DONE(ev[3]),
        .MON_PACKET_START(ev[4]), .MON_PACKET_DONE(ev[5]), .TERM_A_CMD_VALID(ev[6]),
        .TERM_A_MSG_DONE(ev[7]), .TERM_B_CMD_VALID(ev[8]), .TERM_B_MSG_DONE(ev[9]),
        .TERM_A_SHUTDOWN(ev[10]), .TERM_A_OVERRIDE(ev[11]), .TERM_B_SHUTDOWN(ev[12]),
        .TERM_B_OVERRIDE(ev[13]), .SHUT_BUS_B(ev[14]), .CHECKSUM_FAIL(ev[15]),
        .RAM_MISMATCH(ev[16]), .SOFT_RESET_DONE_A(ev[17]), .SOFT_RESET_DONE_B(ev[18]),
        .SOFT_RESET_DONE_MON(ev[19]), .HOST_WRITE(hw), .HOST_WDATA(hwd), .PEND_READ(pr),
        .STATUS_WORD(sw_out), .TERM_A_BIT_WORD(a_word), .TERM_B_BIT_WORD(b_word),
        .HW_PENDING(hp_out), .SOFT_RESET_ACTIVE(sr_act));
    function automatic tsf_exp_s step(tsf_exp_s s, logic [19:0] e, logic w, logic [15:0] d,
                                      logic p);
        tsf_exp_s n  = s;
        logic     go = w && s.sw[12:10] == 3'h0;
        n.sw[8] = e[0] & e[1];
        n.sw[7] = e[2] | (s.sw[7] & ~e[3]);
        n.sw[6] = e[4] | (s.sw[6] & ~e[5]);
        n.sw[5] = e[8] | (s.sw[5] & ~e[9]);
        n.sw[4] = e[6] | (s.sw[4] & ~e[7]);
        n.sw[12:10] = go ? d[12:10] : s.sw[12:10] & ~e[19:17];
        n.sw[2] = e[10] | (s.sw[2] & ~e[11] & ~n.sw[10]);
        n.sw[3] = e[12] | (s.sw[3] & ~e[13] & ~n.sw[11]);
        if (e[10]) n.a = e[14] ? BUS_B_SHUT : BUS_A_SHUT;
        if (e[12]) n.b = e[14] ? BUS_B_SHUT : BUS_A_SHUT;
        n.sw[1:0] = s.sw[1:0] | ({e[15], e[16]} & {2{s.sw[13]}});
        n.hp = (p ? 2'h0 : s.hp) | ({e[15], e[16]} & {2{s.sw[13]}});
        return n;
    endfunction
    always @(posedge clk) begin
        if (rst) begin
            want <= '0;
            want.sw[13] <= pin;
            live <= 0;
        end else begin
            want <= step(want, ev, hw, hwd, pr);
            live <= live + 1;
        end
    end
    always @(negedge clk) begin
        if (!rst && live > 1) begin
            `CHK(sw_out & 16'h3dff, want.sw)
            `CHK(hp_out[14:13], want.hp)
            `CHK(sr_act, |want.sw[12:10])
            if (want.sw[2]) `CHK(a_word, want.a)
            if (want.sw[3]) `CHK(b_word, want.b)
        end
    end
    task automatic close_out;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run(input logic strap, input int n);
        @(posedge clk);
        rst <= 1; pin <= strap; ev <= '0; en <= 0;
        repeat (8) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        ev <= '1; en <= 1;
        repeat (n) begin
            @(posedge clk);
            ev <= 20'($random(seed) & $random(seed) & $random(seed)) | 20'($random(seed) & 3);
            pin <= 1'($random(seed));
        end
    endtask
    initial begin
        run(0, 300);
        run(1, 600);
        run(1, 400);
        close_out;
    end
    initial begin
        #20000;
        errors++;
        close_out;
    end
endmodule // tb_tsf_status
